/* File: include/privilege_mode_pkg.sv */
// Constants and decode helpers for the privilege and address-mode checker
package privilege_mode_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
    localparam logic [7:0] MODE_OFF = 8'h0C;
    localparam logic [7:0] ERR_LO_OFF = 8'h10;
    localparam logic [7:0] ERR_HI_OFF = 8'h14;

    // Control register field positions
    localparam int EXL_BIT = 1;
    localparam int ERL_BIT = 2;
    localparam int KSU_LSB = 3;
    localparam int UX_BIT = 5;
    localparam int SX_BIT = 6;
    localparam int KX_BIT = 7;
    localparam int XX_BIT = 31;

    // Reset leaves the core at error level, hence kernel
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

    // Privilege encodings, same as the select field
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_USER = 2'h2;

    // Interrupt status layout
    localparam int IRQ_W = 2;
    localparam int IRQ_FETCH_BIT = 0;
    localparam int IRQ_DATA_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Mode readback layout
    localparam int MODE_PRIV_LSB = 0;
    localparam int MODE_WIDE_BIT = 2;
    localparam int MODE_L3_BIT = 3;
    localparam int MODE_L4_BIT = 4;

    // Privilege level from the control word
    function automatic logic [1:0] priv_decode(input logic [31:0] c);
        logic [1:0] privilege_select_field;
        privilege_select_field = c[KSU_LSB +: 2];
        if (c[ERL_BIT] | c[EXL_BIT])
            priv_decode = PRIV_KERNEL;
        else if (privilege_select_field == PRIV_USER)
            priv_decode = PRIV_USER;
        else if (privilege_select_field == PRIV_SUPER)
            priv_decode = PRIV_SUPER;
        else
            priv_decode = PRIV_KERNEL;
    endfunction

endpackage

/* File: src/address_region_check.sv */
// Virtual address legality check for the current privilege and width
`timescale 1ns/10ps
module address_region_check
(
    input wire logic [1:0] priv_i,
    input wire logic wide_i,
    input wire logic user_wide_i,
    input wire logic fetch_i,
    input wire logic [63:0] vaddr_i,
    output logic error_o
);
    wire fetch_bad = fetch_i & (|vaddr_i[63:31]);
    // Narrow mode: high word must copy bit 31
    wire narrow_ext_ok = (vaddr_i[63:32] == {32{vaddr_i[31]}});
    wire sign_ext_ok = (vaddr_i[58:44] == {15{vaddr_i[43]}});
    wire [1:0] region = vaddr_i[63:62];
    wire is_user = (priv_i == privilege_mode_pkg::PRIV_USER);
    wire is_super = (priv_i == privilege_mode_pkg::PRIV_SUPER);
    wire user32_bad = vaddr_i[31];
    wire user64_bad = |vaddr_i[63:44];
    // narrow supervisor: user or supervisor segment
    wire sup32_ok = ~vaddr_i[31] | (vaddr_i[31:29] == 3'h6);
    wire xsuseg_ok = (region == 2'h0) & ~(|vaddr_i[61:44]) & (user_wide_i | ~(|vaddr_i[43:31]));
    wire xsseg_ok = (region == 2'h1) & ~(|vaddr_i[61:44]);
    wire csseg_ok = (&vaddr_i[63:32]) & (vaddr_i[31:29] == 3'h6);
    wire sup64_ok = xsuseg_ok | xsseg_ok | csseg_ok;
    // kernel: unmapped region exempt from sign rule
    wire kern64_ok = (region == 2'h2) | sign_ext_ok;
    logic mode_bad;

    always_comb
    begin
        mode_bad = 1'b0;
        if (!wide_i)
        begin
            if (!narrow_ext_ok)
                mode_bad = 1'b1;
            else if (is_user)
                mode_bad = user32_bad;
            else if (is_super)
                mode_bad = ~sup32_ok;
        end
        else
        begin
            if (is_user)
                mode_bad = user64_bad;
            else if (is_super)
                mode_bad = ~sup64_ok;
            else
                mode_bad = ~kern64_ok;
        end
    end

    assign error_o = fetch_bad | mode_bad;
endmodule // address_region_check

/* File: src/privilege_mode_check.sv */
// Privilege and addressing mode decode with address error check
//
// Summary of operation
// - With both level flags clear, select field 10 gives user, 01 supervisor and 00 kernel, set by software.
// - Error level (bit 2) or exception level (bit 1) forces kernel, all levels on, kernel wide bit picks width.
// - Kernel accepts every instruction and is 64-bit only when the kernel wide bit (bit 7) is set.
// - Supervisor always enables the newest level; its wide bit (bit 6) enables 64-bit and third-level together.
// - User wide bit (bit 5) gives 64-bit and third level; user extension bit (bit 31) gives newest level.
// - Kernel software may read and write every field of the control register.
// - Address bits 43:0 translate, 63:62 select region, 58:44 must copy bit 43 in mapped regions for the wide kernel.
// - User reaches only the user segment, narrow or wide.
// - Supervisor reaches user regions plus its own segment or the wide supervisor segments.
// - Wide kernel reaches every region except mapped ones where bits 58:44 are not a sign extension.
// - A fetch with any of the upper 33 address bits set is an address error.
// - Narrow user addressing errors on any address with its top bit set.
// - Wide user addressing errors when bits 63:44 are not all zero.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module privilege_mode_check
#(
    parameter int REG_ADDR_BITS = 8
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pipeline level events
    input wire logic exc_enter_i,
    input wire logic err_enter_i,
    input wire logic level_return_i,
    // Address check request
    input wire logic chk_valid_i,
    input wire logic chk_fetch_i,
    input wire logic [63:0] chk_vaddr_i,
    // Decoded mode
    output logic [1:0] priv_level_o,
    output logic wide_addr_o,
    output logic isa_level3_en_o,
    output logic isa_level4_en_o,
    // Check answer
    output logic chk_done_o,
    output logic addr_error_o,
    output logic irq_o
);
    // Offsets up to the last error word need five bits
    if (REG_ADDR_BITS < 5 || REG_ADDR_BITS > 8)
    begin : g_addr_bits_check
        $error("REG_ADDR_BITS must be 5 to 8");
    end

    localparam int IRQ_W_L = privilege_mode_pkg::IRQ_W;

    // Stored state
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [IRQ_W_L-1:0] stat_r;
    logic [IRQ_W_L-1:0] stat_nxt;
    logic [IRQ_W_L-1:0] mask_r;
    logic [IRQ_W_L-1:0] mask_nxt;
    logic [63:0] err_addr_r;
    logic [31:0] hrdata_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [1:0] priv_r;
    logic wide_r;
    logic l3_r;
    logic l4_r;
    logic done_r;
    logic err_r;

    // Bus decode
    wire addr_phase = hsel_i & htrans_i[1] & hready_i;
    wire [7:0] req_addr = {{(8-REG_ADDR_BITS){1'b0}}, haddr_i[REG_ADDR_BITS-1:0]};
    wire addr_in_range = ~(|haddr_i[31:REG_ADDR_BITS]);
    wire [7:0] ph_addr = addr_in_range ? req_addr : 8'hFF;
    wire wr_go = wr_pend_r;
    wire wr_ctrl = wr_go & (wr_addr_r == privilege_mode_pkg::CTRL_OFF);
    wire wr_stat = wr_go & (wr_addr_r == privilege_mode_pkg::IRQ_STAT_OFF);
    wire wr_mask = wr_go & (wr_addr_r == privilege_mode_pkg::IRQ_MASK_OFF);

    // Address check against current mode
    logic chk_bad;

    address_region_check u_check
    (
        .priv_i(priv_r),
        .wide_i(wide_r),
        .user_wide_i(ctrl_r[privilege_mode_pkg::UX_BIT]),
        .fetch_i(chk_fetch_i),
        .vaddr_i(chk_vaddr_i),
        .error_o(chk_bad)
    );

    wire chk_err = chk_valid_i & chk_bad;
    wire ev_fetch = chk_err & chk_fetch_i;
    wire ev_data = chk_err & ~chk_fetch_i;
    wire [IRQ_W_L-1:0] ev_set = {ev_data, ev_fetch};

    // Control word update
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt = hwdata_i;
        // Hardware level changes win over software
        if (level_return_i)
        begin
            if (ctrl_nxt[privilege_mode_pkg::ERL_BIT])
                ctrl_nxt[privilege_mode_pkg::ERL_BIT] = 1'b0;
            else
                ctrl_nxt[privilege_mode_pkg::EXL_BIT] = 1'b0;
        end
        if (exc_enter_i)
            ctrl_nxt[privilege_mode_pkg::EXL_BIT] = 1'b1;
        if (err_enter_i)
            ctrl_nxt[privilege_mode_pkg::ERL_BIT] = 1'b1;
    end

    // Write one to clear, new event wins
    wire [IRQ_W_L-1:0] stat_clr = wr_stat ? hwdata_i[IRQ_W_L-1:0] : {IRQ_W_L{1'b0}};
    assign stat_nxt = (stat_r & ~stat_clr) | ev_set;
    assign mask_nxt = wr_mask ? hwdata_i[IRQ_W_L-1:0] : mask_r;

    wire [1:0] priv_nxt = privilege_mode_pkg::priv_decode(ctrl_nxt);
    wire is_k = (priv_nxt == privilege_mode_pkg::PRIV_KERNEL);
    wire is_s = (priv_nxt == privilege_mode_pkg::PRIV_SUPER);
    wire kx = ctrl_nxt[privilege_mode_pkg::KX_BIT];
    wire sx = ctrl_nxt[privilege_mode_pkg::SX_BIT];
    wire ux = ctrl_nxt[privilege_mode_pkg::UX_BIT];
    wire xx = ctrl_nxt[privilege_mode_pkg::XX_BIT];
    logic wide_nxt;
    logic l3_nxt;
    logic l4_nxt;

    always_comb
    begin
        if (is_k)
        begin
            wide_nxt = kx;
            l3_nxt = 1'b1;
            l4_nxt = 1'b1;
        end
        else if (is_s)
        begin
            wide_nxt = sx;
            l3_nxt = sx;
            l4_nxt = 1'b1;
        end
        else
        begin
            wide_nxt = ux;
            l3_nxt = ux;
            l4_nxt = xx;
        end
    end

    // Read mux uses next values so a read after a write sees it
    wire [31:0] mode_word = {27'h0, l4_nxt, l3_nxt, wide_nxt, priv_nxt};
    logic [31:0] rd_val;

    always_comb
    begin
        case (ph_addr)
            privilege_mode_pkg::CTRL_OFF: rd_val = ctrl_nxt;
            privilege_mode_pkg::IRQ_STAT_OFF: rd_val = {{(32-IRQ_W_L){1'b0}}, stat_nxt};
            privilege_mode_pkg::IRQ_MASK_OFF: rd_val = {{(32-IRQ_W_L){1'b0}}, mask_nxt};
            privilege_mode_pkg::MODE_OFF: rd_val = mode_word;
            privilege_mode_pkg::ERR_LO_OFF: rd_val = err_addr_r[31:0];
            privilege_mode_pkg::ERR_HI_OFF: rd_val = err_addr_r[63:32];
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Bus phase tracking
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= addr_phase & hwrite_i;
            if (addr_phase)
                wr_addr_r <= ph_addr;
            if (addr_phase & ~hwrite_i)
                hrdata_r <= rd_val;
        end
    end

    // Register file
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl_r <= privilege_mode_pkg::CTRL_RESET;
            stat_r <= privilege_mode_pkg::IRQ_RESET;
            mask_r <= privilege_mode_pkg::IRQ_RESET;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            priv_r <= privilege_mode_pkg::PRIV_KERNEL;
            wide_r <= 1'b0;
            l3_r <= 1'b1;
            l4_r <= 1'b1;
        end
        else
        begin
            priv_r <= priv_nxt;
            wide_r <= wide_nxt;
            l3_r <= l3_nxt;
            l4_r <= l4_nxt;
        end
    end

    // Check answer, one cycle after the request
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            err_addr_r <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            done_r <= chk_valid_i;
            err_r <= chk_err;
            if (chk_err)
                err_addr_r <= chk_vaddr_i;
        end
    end

    // Zero wait state slave, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;
    assign priv_level_o = priv_r;
    assign wide_addr_o = wide_r;
    assign isa_level3_en_o = l3_r;
    assign isa_level4_en_o = l4_r;
    assign chk_done_o = done_r;
    assign addr_error_o = err_r;
    assign irq_o = |(stat_r & mask_r);
endmodule // privilege_mode_check

/* File: tb/pipe_model.sv */
// Pipeline side model raising level events and address checks
`timescale 1ns/10ps
module pipe_model
(
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic error_i,
    output logic exc_o,
    output logic err_o,
    output logic ret_o,
    output logic valid_o,
    output logic fetch_o,
    output logic [63:0] vaddr_o
);
    initial
    begin
        {err_o, exc_o, ret_o, valid_o, fetch_o} = 5'h0;
        vaddr_o = 64'h0;
    end
    task automatic pulse(input logic [2:0] k);
        {err_o, exc_o, ret_o} <= k;
        @(posedge clk_i);
        {err_o, exc_o, ret_o} <= 3'h0;
    endtask
    task automatic probe(input logic f, input logic [63:0] a, output logic [1:0] r);
        valid_o <= 1'b1;
        fetch_o <= f;
        vaddr_o <= a;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // Released address flips so a stale value never passes
        vaddr_o <= ~a;
        @(posedge clk_i);
        r = {done_i, error_i};
    endtask
endmodule // pipe_model

/* File: tb/privilege_mode_check_checker.sv */
// Checker for mode decode and address check timing
`timescale 1ns/10ps
module privilege_mode_check_checker
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic err_enter_i,
    input wire logic chk_valid_i,
    input wire logic chk_fetch_i,
    input wire logic [63:0] chk_vaddr_i,
    input wire logic [1:0] priv_level_o,
    input wire logic wide_addr_o,
    input wire logic isa_level3_en_o,
    input wire logic isa_level4_en_o,
    input wire logic chk_done_o,
    input wire logic addr_error_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_answer_follows: assert property (chk_valid_i |=> chk_done_o)
        else $error("check answer missing");
    a_answer_cause: assert property (chk_done_o |-> $past(chk_valid_i))
        else $error("answer without request");
    a_fetch_upper: assert property (chk_valid_i && chk_fetch_i && chk_vaddr_i[63:31] != 33'h0 |=> addr_error_o)
        else $error("fetch error missed");
    a_user_narrow: assert property (chk_valid_i && priv_level_o == 2'h2 && !wide_addr_o && chk_vaddr_i[31]
        |=> addr_error_o)
        else $error("narrow user error missed");
    a_user_wide: assert property (chk_valid_i && priv_level_o == 2'h2 && wide_addr_o
        && chk_vaddr_i[63:44] != 20'h0 |=> addr_error_o)
        else $error("wide user error missed");
    a_error_kernel: assert property (err_enter_i |=> priv_level_o == 2'h0 && isa_level3_en_o && isa_level4_en_o)
        else $error("error level not kernel");
    a_kernel_isa: assert property (priv_level_o == 2'h0 |-> isa_level3_en_o && isa_level4_en_o)
        else $error("kernel level disabled");
    a_super_isa: assert property (priv_level_o == 2'h1 |-> isa_level4_en_o && isa_level3_en_o == wide_addr_o)
        else $error("supervisor enables wrong");
    a_user_isa: assert property (priv_level_o == 2'h2 |-> isa_level3_en_o == wide_addr_o)
        else $error("user enables wrong");
    a_priv_legal: assert property (priv_level_o != 2'h3)
        else $error("illegal privilege code");
endmodule // privilege_mode_check_checker

bind privilege_mode_check privilege_mode_check_checker chk (.clk_i, .reset_i, .err_enter_i, .chk_valid_i,
    .chk_fetch_i, .chk_vaddr_i, .priv_level_o, .wide_addr_o, .isa_level3_en_o, .isa_level4_en_o,
    .chk_done_o, .addr_error_o);

/* File: tb/privilege_mode_check_tb.sv */
// Bench for the privilege mode decoder and address checker
`timescale 1ns/10ps
module privilege_mode_check_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, exc_enter_i, err_enter_i, level_return_i, chk_valid_i, chk_fetch_i;
    logic [63:0] chk_vaddr_i;
    logic [1:0] priv_level_o;
    logic wide_addr_o, isa_level3_en_o, isa_level4_en_o, chk_done_o, addr_error_o, irq_o;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clk_i = ~clk_i;
    pipe_model pm (.clk_i, .done_i(chk_done_o), .error_i(addr_error_o), .exc_o(exc_enter_i),
        .err_o(err_enter_i), .ret_o(level_return_i), .valid_o(chk_valid_i), .fetch_o(chk_fetch_i),
        .vaddr_o(chk_vaddr_i));
    privilege_mode_check uut (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .exc_enter_i, .err_enter_i,
        .level_return_i, .chk_valid_i, .chk_fetch_i, .chk_vaddr_i, .priv_level_o, .wide_addr_o,
        .isa_level3_en_o, .isa_level4_en_o, .chk_done_o, .addr_error_o, .irq_o);
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        // Whole run needs about 150 cycles
        if (cycles == 2000)
        begin
            bad_count = bad_count + 1;
            conclude;
        end
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        r = hrdata_o;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask
    task automatic tmode(input logic [31:0] c, input logic [4:0] e);
        wr(32'h0, c);
        rd(32'h0, c);
        rd(32'h0C, {27'h0, e});
        cmp({27'h0, isa_level4_en_o, isa_level3_en_o, wide_addr_o, priv_level_o}, {27'h0, e});
    endtask
    task automatic tchk(input logic [31:0] c, input logic f, input logic [63:0] a, input logic e);
        logic [1:0] r;
        wr(32'h0, c);
        pm.probe(f, a, r);
        cmp({30'h0, r}, {30'h0, 1'b1, e});
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(32'h0, 32'h4);
        rd(32'h0C, 32'h18);
        rd(32'h100, 32'h0);
        tmode(32'h10, 5'h02);
        tmode(32'h8000_0010, 5'h12);
        tmode(32'h30, 5'h0E);
        tmode(32'h08, 5'h11);
        tmode(32'h48, 5'h1D);
        tmode(32'h80, 5'h1C);
        tmode(32'h12, 5'h18);
        tmode(32'h94, 5'h1C);
        wr(32'h0, 32'h10);
        pm.pulse(3'h4);
        rd(32'h0, 32'h14);
        pm.pulse(3'h1);
        rd(32'h0, 32'h10);
        pm.pulse(3'h2);
        rd(32'h0C, 32'h18);
        wr(32'h08, 32'h3);
        rd(32'h08, 32'h3);
        cmp({31'h0, hresp_o}, 32'h0);
        tchk(32'h10, 1'b0, 64'h0000_0000_7FFF_FFF0, 1'b0);
        tchk(32'h10, 1'b0, 64'hFFFF_FFFF_8000_0000, 1'b1);
        tchk(32'h30, 1'b0, 64'h0000_0FFF_FFFF_FFF0, 1'b0);
        tchk(32'h30, 1'b0, 64'h0000_1000_0000_0000, 1'b1);
        tchk(32'h08, 1'b0, 64'hFFFF_FFFF_C000_0000, 1'b0);
        tchk(32'h08, 1'b0, 64'hFFFF_FFFF_8000_0000, 1'b1);
        tchk(32'h48, 1'b0, 64'h4000_0000_0000_0000, 1'b0);
        tchk(32'h80, 1'b0, 64'h8000_0000_0000_0000, 1'b0);
        tchk(32'h80, 1'b0, 64'h0000_1000_0000_0000, 1'b1);
        tchk(32'h80, 1'b0, 64'hFFFF_F800_0000_0000, 1'b0);
        tchk(32'h0, 1'b0, 64'hFFFF_FFFF_8000_0000, 1'b0);
        wr(32'h04, 32'h3);
        // Clear lands on the write's last edge, look one edge later
        @(posedge clk_i);
        cmp({31'h0, irq_o}, 32'h0);
        // Wide kernel keeps the region legal, so only the fetch rule can fire
        tchk(32'h80, 1'b1, 64'h0000_0000_8000_0000, 1'b1);
        cmp({31'h0, irq_o}, 32'h1);
        rd(32'h04, 32'h1);
        wr(32'h04, 32'h1);
        wr(32'h08, 32'h0);
        tchk(32'h80, 1'b1, 64'h0000_0001_0000_0000, 1'b1);
        cmp({31'h0, irq_o}, 32'h0);
        rd(32'h04, 32'h1);
        rd(32'h10, 32'h0);
        rd(32'h14, 32'h1);
        conclude;
    end
endmodule // privilege_mode_check_tb
